// ===== pkg/wwd_pkg.sv
// Purpose: Shared constants and types of the windowed watchdog block
// Assumes: 32-bit AHB-Lite register window, one clock
// Notes: Byte address of a register is four times its index
package wwd_pkg;

	// ************************************************
	// Sizes
	// ************************************************
	localparam int unsigned PSC_W = 18;
	localparam int unsigned TMR_W = 5;
	localparam int unsigned SRC_N = 4;

	// ************************************************
	// Register indices and byte addresses
	// ************************************************
	localparam logic [29:0] IDX_CON0 = 30'h78;
	localparam logic [29:0] IDX_CON1 = 30'h79;
	localparam logic [29:0] IDX_PSL = 30'h7a;
	localparam logic [29:0] IDX_PSH = 30'h7b;
	localparam logic [29:0] IDX_TMR = 30'h7c;
	localparam logic [31:0] ADDR_CON0 = {IDX_CON0, 2'h0};
	localparam logic [31:0] ADDR_CON1 = {IDX_CON1, 2'h0};
	localparam logic [31:0] ADDR_PSL = {IDX_PSL, 2'h0};
	localparam logic [31:0] ADDR_PSH = {IDX_PSH, 2'h0};
	localparam logic [31:0] ADDR_TMR = {IDX_TMR, 2'h0};

	// ************************************************
	// Field positions
	// ************************************************
	localparam int unsigned SEN_BIT = 0;
	localparam int unsigned PS_LSB = 1;
	localparam int unsigned PS_MSB = 5;
	localparam int unsigned WIN_LSB = 0;
	localparam int unsigned WIN_MSB = 2;
	localparam int unsigned CS_LSB = 4;
	localparam int unsigned CS_MSB = 6;

	// ************************************************
	// Reset values and codes
	// ************************************************
	localparam logic SEN_RST = 1'b0;
	localparam logic [4:0] PS_RST = 5'h0b;
	localparam logic [4:0] PS_FREE = 5'h1f;
	localparam logic [4:0] PS_MAX = 5'h12;
	localparam logic [2:0] CS_RST = 3'h0;
	localparam logic [2:0] CS_FREE = 3'h7;
	localparam logic [2:0] WIN_FREE = 3'h7;
	localparam logic [2:0] CS_LAST = 3'h3;
	localparam logic [1:0] MODE_SW = 2'h1;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [TMR_W-1:0] TMR_MAX = 5'h1f;
	localparam logic WVF_RST = 1'b1;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic HRESP_OKAY = 1'b0;

	// Start-up sequence: load fuse-derived values, then run
	typedef enum logic {ST_LOAD, ST_RUN} wwd_state_t;

endpackage : wwd_pkg

// ===== pkg/wwd_cnt_if.sv
// Purpose: Carrier between the control logic and the counter chain
// Assumes: Both ends on hclk
// Notes: period is already mapped, reserved codes removed
`timescale 1ns/1ps
`default_nettype none
interface wwd_cnt_if;
	import wwd_pkg::*;
	logic tick;
	logic clear;
	logic enable;
	logic [4:0] period;
	logic [PSC_W-1:0] psc;
	logic [TMR_W-1:0] tmr;
	logic timeout;
	modport ctl (output tick, clear, enable, period,
		input psc, tmr, timeout);
	modport cnt (input tick, clear, enable, period,
		output psc, tmr, timeout);
endinterface : wwd_cnt_if
`default_nettype wire

// ===== logic/wwd_sync.sv
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Bits are independent levels
// Notes: Only the second stage may be read by other logic
`timescale 1ns/1ps
`default_nettype none
module wwd_sync #(
	parameter int unsigned W = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stage1;

	// First stage feeds only the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1 <= '0;
			dout <= '0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule : wwd_sync
`default_nettype wire

// ===== logic/wwd_counter.sv
// Purpose: Prescaler and five-bit window counter
// Assumes: tick is a one-cycle pulse per watchdog clock edge
// Notes: Timer steps when the low period bits of the prescaler wrap
`timescale 1ns/1ps
`default_nettype none
module wwd_counter
	import wwd_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	wwd_cnt_if.cnt cif
);
	logic [PSC_W-1:0] next_psc;
	logic [TMR_W-1:0] next_tmr;
	logic [PSC_W-1:0] mask;
	logic tap;

	// Divide by 2^(5+period): 32 timer steps of 2^period ticks
	assign mask = (18'h1 << cif.period) - 18'h1; // RULE_01
	assign tap = ((cif.psc & mask) == mask);
	assign cif.timeout = cif.tick && cif.enable && !cif.clear && tap &&
		(cif.tmr == TMR_MAX); // RULE_18

	// Clear beats counting
	always_comb begin
		next_psc = cif.psc;
		next_tmr = cif.tmr;
		if (cif.clear) begin
			next_psc = '0; // RULE_19
			next_tmr = '0;
		end else if (cif.tick && cif.enable) begin
			next_psc = cif.psc + 18'h1; // RULE_19
			if (tap) begin
				next_tmr = cif.tmr + 5'h1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cif.psc <= '0; // RULE_14
			cif.tmr <= '0;
		end else begin
			cif.psc <= next_psc;
			cif.tmr <= next_tmr;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	tmr_step_a: assert property ( // RULE_19
		cif.tick && cif.enable && !cif.clear && tap &&
		cif.tmr != TMR_MAX |=> cif.tmr == $past(cif.tmr) + 5'h1)
		else $error("timer did not step on prescaler tap");
	short_period_a: assert property ( // RULE_01
		cif.period == 5'h0 && cif.enable && cif.tick && !cif.clear &&
		cif.tmr != TMR_MAX |=> cif.tmr == $past(cif.tmr) + 5'h1)
		else $error("code zero must step timer every tick");
	clear_zero_a: assert property ( // RULE_19
		cif.clear |=> cif.psc == '0 && cif.tmr == '0)
		else $error("clear did not zero counters");
	timeout_c: cover property (cif.timeout);
endmodule : wwd_counter
`default_nettype wire

// ===== logic/wwd_top.sv
// Purpose: Windowed watchdog registers, arming, window and reset logic
// Assumes: Fuse fields are static; clear command comes from hclk logic
// Notes: Zero-wait AHB-Lite slave, read data registered at address phase
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE_01: Period code 0 divides by 32, each step doubles, code 18 gives 2^23.
// RULE_02: Reserved period codes 19 to 31 act as the shortest interval.
// RULE_03: Period resets to 11 when fuse period is all ones, else fuse value.
// RULE_04: Period field ignores writes unless fuse period is all ones.
// RULE_05: Software enable rules only in fuse mode 01; ignored otherwise.
// RULE_06: Clock select 0 low osc, 1 mid osc, 2 secondary, 3 external.
// RULE_07: Clock select resets to 0 when fuse clock select is all ones.
// RULE_08: Clock select ignores writes unless fuse clock select is all ones.
// RULE_09: Window code sets open share, 7 fully open, each lower 12.5% less.
// RULE_10: Window field reset value comes from fuse window size.
// RULE_11: Window field ignores writes unless fuse window size is all ones.
// RULE_12: Timer bits readable; window closed while they lie below threshold.
// RULE_13: Armed flag readable in status bit 2.
// RULE_14: 18-bit prescaler count readable in three bytes, resets to zero.
// RULE_15: Windowed clear needs a prior control 0 read, else violation.
// RULE_16: Window violation raises reset and clears violation flag.
// RULE_17: Any write to either control register clears the count.
// RULE_18: No valid clear within the period raises a reset.
// RULE_19: Prescaler runs from chosen source, timer from tap; clear zeroes both.
module wwd_top
	import wwd_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [1:0] fuse_operating_mode,
	input wire logic [4:0] fuse_period_field,
	input wire logic [2:0] fuse_clock_select_field,
	input wire logic [2:0] fuse_window_size_field,
	input wire logic low_freq_internal_osc,
	input wire logic mid_freq_internal_osc,
	input wire logic secondary_osc,
	input wire logic external_osc,
	input wire logic watchdog_clear_command,
	input wire logic window_violation_set,
	output logic watchdog_reset,
	output logic window_violation_flag,
	output logic watchdog_active
);

	// ************************************************
	// Declarations
	// ************************************************
	wwd_state_t state, next_state;
	logic software_enable_bit, next_sen;
	logic [4:0] period_select, next_ps;
	logic [2:0] clock_source_field, next_cs;
	logic [2:0] window_sel, next_win;
	logic armed, next_armed;
	logic wr_con0, next_wr_con0;
	logic wr_con1, next_wr_con1;
	logic [31:0] next_hrdata;
	logic next_reset;
	logic next_wvf;
	logic [SRC_N-1:0] osc_sync, osc_prev, osc_rise;
	logic addr_ok, rd_req, rd_con0;
	logic windowed, win_open, clr_cmd, clr_valid, violation;
	logic [TMR_W-1:0] threshold;
	logic [4:0] eff_period;
	logic tick;
	wwd_cnt_if cif ();

	// ************************************************
	// Clock source pins and counter chain
	// ************************************************

	// Pins come from other oscillators, so resample first
	wwd_sync #(.W(SRC_N)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.din({external_osc, secondary_osc, mid_freq_internal_osc,
			low_freq_internal_osc}),
		.dout(osc_sync)
	);

	// Rising-edge detect on the synchronised levels
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_prev <= '0;
		end else begin
			osc_prev <= osc_sync;
		end
	end
	assign osc_rise = osc_sync & ~osc_prev;

	// Reserved sources give no tick, so the watchdog stalls there
	always_comb begin
		tick = 1'b0;
		if (clock_source_field <= CS_LAST) begin
			tick = osc_rise[clock_source_field[1:0]]; // RULE_06
		end
	end

	// Reserved period codes fall back to the shortest interval
	assign eff_period = (period_select > PS_MAX) ? 5'h0 :
		period_select; // RULE_02

	// Mode 1x always runs; 01 follows software; 00 never runs
	assign watchdog_active = (state == ST_RUN) &&
		(fuse_operating_mode[1] ||
		(fuse_operating_mode == MODE_SW && software_enable_bit)); // RULE_05

	assign cif.tick = tick;
	assign cif.enable = watchdog_active;
	assign cif.period = eff_period;
	assign cif.clear = !watchdog_active || clr_valid || wr_con0 ||
		wr_con1 || watchdog_reset; // RULE_17

	wwd_counter u_counter (
		.hclk(hclk),
		.hresetn(hresetn),
		.cif(cif)
	);

	// ************************************************
	// Window and clear command
	// ************************************************

	// Threshold is (7 - window) * 4 on the five timer bits
	assign threshold = {~window_sel, 2'h0}; // RULE_09
	assign win_open = (cif.tmr >= threshold); // RULE_12
	assign windowed = (window_sel != WIN_FREE);
	assign clr_cmd = watchdog_clear_command && watchdog_active;
	// A windowed clear needs arming even when the window is open
	assign clr_valid = clr_cmd && win_open && (armed || !windowed);
	assign violation = clr_cmd && !clr_valid; // RULE_15

	// ************************************************
	// Bus slave
	// ************************************************
	assign addr_ok = hsel && hready && (htrans != HTRANS_IDLE) &&
		htrans[1];
	assign rd_req = addr_ok && !hwrite;
	assign rd_con0 = rd_req && (haddr == ADDR_CON0);
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;

	// Read mux; unmapped and reserved bits read zero
	always_comb begin
		next_hrdata = '0;
		if (rd_req) begin
			if (haddr == ADDR_CON0) begin
				next_hrdata[PS_MSB:PS_LSB] = period_select;
				next_hrdata[SEN_BIT] = software_enable_bit;
			end else if (haddr == ADDR_CON1) begin
				next_hrdata[CS_MSB:CS_LSB] = clock_source_field;
				next_hrdata[WIN_MSB:WIN_LSB] = window_sel;
			end else if (haddr == ADDR_PSL) begin
				next_hrdata[7:0] = cif.psc[7:0]; // RULE_14
			end else if (haddr == ADDR_PSH) begin
				next_hrdata[7:0] = cif.psc[15:8]; // RULE_14
			end else if (haddr == ADDR_TMR) begin
				next_hrdata[7:3] = cif.tmr; // RULE_12
				next_hrdata[2] = armed; // RULE_13
				next_hrdata[1:0] = cif.psc[17:16]; // RULE_14
			end
		end
	end

	// Writes land in the data phase after the address is taken
	assign next_wr_con0 = addr_ok && hwrite && (haddr == ADDR_CON0);
	assign next_wr_con1 = addr_ok && hwrite && (haddr == ADDR_CON1);

	// ************************************************
	// Control registers
	// ************************************************

	// Fuses are ports, so their values load on the first clocked edge
	always_comb begin
		next_state = ST_RUN;
		next_sen = software_enable_bit;
		next_ps = period_select;
		next_cs = clock_source_field;
		next_win = window_sel;
		case (state)
			ST_LOAD: begin
				next_ps = (fuse_period_field == PS_FREE) ? PS_RST :
					fuse_period_field; // RULE_03
				next_cs = (fuse_clock_select_field == CS_FREE) ? CS_RST :
					fuse_clock_select_field; // RULE_07
				next_win = fuse_window_size_field; // RULE_10
			end
			ST_RUN: begin
				if (wr_con0) begin
					next_sen = hwdata[SEN_BIT];
					if (fuse_period_field == PS_FREE) begin
						next_ps = hwdata[PS_MSB:PS_LSB]; // RULE_04
					end
				end
				if (wr_con1) begin
					if (fuse_clock_select_field == CS_FREE) begin
						next_cs = hwdata[CS_MSB:CS_LSB]; // RULE_08
					end
					if (fuse_window_size_field == WIN_FREE) begin
						next_win = hwdata[WIN_MSB:WIN_LSB]; // RULE_11
					end
				end
			end
			default: next_state = ST_LOAD;
		endcase
	end

	// Arming by a control 0 read wins over a same-cycle disarm
	always_comb begin
		next_armed = armed;
		if (!watchdog_active || clr_cmd || watchdog_reset) begin
			next_armed = 1'b0;
		end
		if (rd_con0) begin
			next_armed = 1'b1; // RULE_15
		end
	end

	// Hardware clear of the flag wins over a software set
	always_comb begin
		next_reset = violation || cif.timeout; // RULE_16 RULE_18
		next_wvf = window_violation_flag;
		if (window_violation_set) begin
			next_wvf = 1'b1;
		end
		if (violation) begin
			next_wvf = 1'b0; // RULE_16
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_LOAD;
			software_enable_bit <= SEN_RST;
			period_select <= PS_RST;
			clock_source_field <= CS_RST;
			window_sel <= WIN_FREE;
			armed <= 1'b0;
			wr_con0 <= 1'b0;
			wr_con1 <= 1'b0;
			hrdata <= '0;
			watchdog_reset <= 1'b0;
			window_violation_flag <= WVF_RST;
		end else begin
			state <= next_state;
			software_enable_bit <= next_sen;
			period_select <= next_ps;
			clock_source_field <= next_cs;
			window_sel <= next_win;
			armed <= next_armed;
			wr_con0 <= next_wr_con0;
			wr_con1 <= next_wr_con1;
			hrdata <= next_hrdata;
			watchdog_reset <= next_reset;
			window_violation_flag <= next_wvf;
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	ps_default_a: assert property ( // RULE_03
		state == ST_LOAD && fuse_period_field == PS_FREE
		|=> period_select == PS_RST)
		else $error("period did not take its default");
	ps_lock_a: assert property ( // RULE_04
		state == ST_RUN && fuse_period_field != PS_FREE
		|-> period_select == fuse_period_field)
		else $error("locked period field changed");
	cs_lock_a: assert property ( // RULE_08
		state == ST_RUN && fuse_clock_select_field != CS_FREE
		|-> clock_source_field == fuse_clock_select_field)
		else $error("locked clock select changed");
	win_lock_a: assert property ( // RULE_11
		state == ST_RUN |-> window_sel == fuse_window_size_field ||
		fuse_window_size_field == WIN_FREE)
		else $error("locked window field changed");
	mode_off_a: assert property ( // RULE_05
		fuse_operating_mode == MODE_OFF |-> !watchdog_active)
		else $error("watchdog ran in fuse mode off");
	reserved_ps_a: assert property ( // RULE_02
		period_select > PS_MAX |-> cif.period == 5'h0)
		else $error("reserved period not shortest");
	unarmed_clr_a: assert property ( // RULE_15
		clr_cmd && windowed && !armed
		|=> watchdog_reset && !window_violation_flag)
		else $error("unarmed clear did not violate");
	closed_clr_a: assert property ( // RULE_12
		clr_cmd && cif.tmr < {~window_sel, 2'h0} |=> watchdog_reset)
		else $error("clear in closed window accepted");
	arm_read_a: assert property ( // RULE_13
		rd_con0 |=> armed)
		else $error("arming read did not set armed");
	write_clr_a: assert property ( // RULE_17
		next_wr_con0 || next_wr_con1 |=> ##1 cif.psc == '0 &&
		cif.tmr == '0)
		else $error("control write did not clear count");
	timeout_rst_a: assert property ( // RULE_18
		cif.timeout |=> watchdog_reset ##1 cif.tmr == '0)
		else $error("timeout did not raise reset");

	viol_c: cover property (violation);
	valid_clr_c: cover property (clr_valid && windowed);
	timeout_c: cover property (cif.timeout);
	arm_then_clr_c: cover property (rd_con0 ##[1:20] clr_valid);

endmodule : wwd_top
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the windowed watchdog register block
// Assumes: Zero-wait slave; source clocks far slower than hclk
// Notes: Fuse inputs change only while reset is held low
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import wwd_pkg::*;
;

	// ************************************************
	// Signals
	// ************************************************
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic [1:0] f_mode;
	logic [4:0] f_period;
	logic [2:0] f_cs;
	logic [2:0] f_win;
	logic [3:0] osc;
	logic clr_cmd;
	logic wv_set;
	logic wd_rst;
	logic wv_flag;
	logic wd_active;
	logic [31:0] v;
	logic [4:0] pcode [4];
	int bad_count = 0;
	int total_checks = 0;
	int rst_seen = 0;
	int n;

	// Clock of 4 ns
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	// Slave ready feeds straight back as the bus ready
	wwd_top u_dut (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.fuse_operating_mode(f_mode),
		.fuse_period_field(f_period),
		.fuse_clock_select_field(f_cs),
		.fuse_window_size_field(f_win),
		.low_freq_internal_osc(osc[0]),
		.mid_freq_internal_osc(osc[1]),
		.secondary_osc(osc[2]),
		.external_osc(osc[3]),
		.watchdog_clear_command(clr_cmd),
		.window_violation_set(wv_set),
		.watchdog_reset(wd_rst),
		.window_violation_flag(wv_flag),
		.watchdog_active(wd_active)
	);

	// Count reset request cycles; each request is a one-cycle pulse
	always @(posedge hclk) begin
		if (wd_rst === 1'b1)
			rst_seen <= rst_seen + 1;
	end

	// ************************************************
	// Tasks
	// ************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Single word transfer; read data is taken at the data phase edge
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [7:0] d, output logic [31:0] q);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= HTRANS_IDLE;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask : wr

	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask : rchk

	// Fuses settle while reset is low, so the loaded values are clean
	task automatic do_reset(input logic [1:0] m, input logic [4:0] p,
		input logic [2:0] c, input logic [2:0] w);
		hresetn <= 1'b0;
		f_mode <= m;
		f_period <= p;
		f_cs <= c;
		f_win <= w;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask : do_reset

	// Half period of four cycles keeps the source above the sync limit
	task automatic tick(input int idx, input int cnt);
		repeat (cnt) begin
			osc[idx] <= 1'b1;
			repeat (4) @(posedge hclk);
			osc[idx] <= 1'b0;
			repeat (4) @(posedge hclk);
		end
		repeat (4) @(posedge hclk);
	endtask : tick

	task automatic clear_pulse;
		clr_cmd <= 1'b1;
		@(posedge hclk);
		clr_cmd <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask : clear_pulse

	task automatic final_report;
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	// ************************************************
	// Tests
	// ************************************************
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = HTRANS_IDLE;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		f_mode = 2'h3;
		f_period = 5'h1f;
		f_cs = 3'h7;
		f_win = 3'h7;
		osc = 4'h0;
		clr_cmd = 1'b0;
		wv_set = 1'b0;
		pcode = '{5'h00, 5'h01, 5'h13, 5'h1f};
		// Status read before control 0, which would arm
		do_reset(2'h3, 5'h1f, 3'h7, 3'h7);
		rchk(ADDR_TMR, 32'h00);
		rchk(ADDR_PSL, 32'h00);
		rchk(ADDR_PSH, 32'h00);
		rchk(ADDR_CON0, 32'h16);
		rchk(ADDR_CON1, 32'h07);
		chk({31'h0, wv_flag}, 32'h1);
		wr(ADDR_CON0, 8'hff);
		rchk(ADDR_CON0, 32'h3f);
		wr(ADDR_CON1, 8'hff);
		rchk(ADDR_CON1, 32'h77);
		rchk(32'h1f4, 32'h00);
		chk({31'h0, hresp}, 32'h0);
		$display("reset and access test done");
		// Fuse-owned fields keep their values against writes
		do_reset(2'h3, 5'h03, 3'h2, 3'h4);
		rchk(ADDR_CON0, 32'h06);
		ahb(1'b0, ADDR_CON1, 8'h00, v);
		chk(v & 32'h07, 32'h04);
		wr(ADDR_CON0, 8'h3f);
		rchk(ADDR_CON0, 32'h07);
		wr(ADDR_CON1, ~v[7:0]);
		rchk(ADDR_CON1, v);
		$display("locked field test done");
		// Every operating mode with the enable bit low and high
		for (int m = 0; m < 4; m++) begin
			do_reset(m[1:0], 5'h1f, 3'h7, 3'h7);
			wr(ADDR_CON0, 8'h16);
			@(posedge hclk);
			chk({31'h0, wd_active}, {31'h0, m[1]});
			wr(ADDR_CON0, 8'h17);
			@(posedge hclk);
			chk({31'h0, wd_active}, {31'h0, (m != 0)});
		end
		$display("operating mode test done");
		// Twenty ticks: code 0 steps the timer each tick, code 1 every other
		do_reset(2'h3, 5'h1f, 3'h7, 3'h7);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CON0, {2'h0, pcode[i], 1'b0});
			tick(0, 20);
			rchk(ADDR_PSL, 32'h14);
			ahb(1'b0, ADDR_TMR, 8'h00, v);
			chk(v >> 3, (pcode[i] == 5'h01) ? 32'ha : 32'h14);
		end
		$display("period code test done");
		// Each source in turn, ending on the low osc; reserved gives no ticks
		for (int c = 4; c >= 0; c--) begin
			wr(ADDR_CON1, {1'b0, c[2:0], 1'b0, 3'h7});
			tick(c % 4, 20);
			rchk(ADDR_PSL, (c < 4) ? 32'h14 : 32'h00);
		end
		for (int k = 0; k < 2; k++) begin
			tick(0, 8);
			wr(k ? ADDR_CON0 : ADDR_CON1, k ? 8'h00 : 8'h07);
			rchk(ADDR_PSL, 32'h00);
		end
		$display("clock source test done");
		// Unarmed clear, closed-window clear, then armed clear when open
		// Code 4: 16 ticks per timer step, 512 ticks per period
		do_reset(2'h3, 5'h1f, 3'h7, 3'h7);
		wr(ADDR_CON1, 8'h04);
		wr(ADDR_CON0, 8'h08);
		n = rst_seen;
		clear_pulse;
		chk(rst_seen - n, 32'h1);
		chk({31'h0, wv_flag}, 32'h0);
		wv_set <= 1'b1;
		@(posedge hclk);
		wv_set <= 1'b0;
		@(posedge hclk);
		chk({31'h0, wv_flag}, 32'h1);
		rchk(ADDR_CON0, 32'h08);
		rchk(ADDR_TMR, 32'h04);
		n = rst_seen;
		clear_pulse;
		chk(rst_seen - n, 32'h1);
		wr(ADDR_CON1, 8'h04);
		tick(0, 384);
		rchk(ADDR_PSL, 32'h80);
		rchk(ADDR_PSH, 32'h01);
		rchk(ADDR_CON0, 32'h08);
		rchk(ADDR_TMR, 32'hc4);
		n = rst_seen;
		clear_pulse;
		chk(rst_seen - n, 32'h0);
		rchk(ADDR_TMR, 32'h00);
		$display("window test done");
		// Full period of 32 x 16 ticks with no clear
		wr(ADDR_CON1, 8'h07);
		n = rst_seen;
		tick(0, 511);
		chk(rst_seen - n, 32'h0);
		tick(0, 1);
		chk(rst_seen - n, 32'h1);
		$display("time-out test done");
		final_report;
	end

	// Tests need about 10000 cycles; a hang ends the run
	initial begin
		repeat (60000) @(posedge hclk);
		bad_count++;
		final_report;
	end

endmodule : tb_top
`default_nettype wire
